// *** verilog/cpsi_pkg.sv ***
`default_nettype none
package cpsi_pkg;
   // -------------------------------------------------------------
   // Bus geometry
   // -------------------------------------------------------------
   localparam int WB_AW = 18;
   localparam int WB_DW = 32;
   localparam int REG_W = 8;

   // -------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -------------------------------------------------------------
   localparam logic [15:0] IDX_PORT_SEL = 16'hFE00;
   localparam logic [15:0] IDX_IRQ_CAUSE = 16'hFE01;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'hFE02;
   localparam logic [15:0] IDX_TX_CTRL = 16'hFE10;
   localparam logic [15:0] IDX_INT_LINE = 16'hFE11;
   localparam logic [15:0] IDX_EXT_LINE = 16'hFE12;
   localparam logic [15:0] IDX_BIT_LEN = 16'hFE13;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int SEL_BYPASS = 1;
   localparam int SEL_SLOT_LO = 2;
   localparam int SEL_SLOT_HI = 3;
   localparam logic [7:0] SEL_WMASK = 8'h0E;
   localparam int TXC_CLK_STOP = 7;
   localparam int TXC_DIRECT = 6;
   localparam int TXC_SYNC = 5;
   localparam int TXC_TX_MODE = 0;
   localparam logic [7:0] TXC_WMASK = 8'hE1;
   localparam int LN_DATA = 0;
   localparam int LN_DIR = 1;
   localparam int LN_SAMPLE = 5;
   localparam logic [7:0] LN_WMASK = 8'h03;
   localparam int IRQ_BIT_LEN = 7;

   // -------------------------------------------------------------
   // Slot select codes
   // -------------------------------------------------------------
   localparam logic [1:0] SLOT_NONE = 2'b00;
   localparam logic [1:0] SLOT_EXT = 2'b01;

   // Pin synchroniser lanes
   localparam int SY_INT_CLK = 0;
   localparam int SY_EXT_CLK = 1;
   localparam int SY_INT_IO = 2;
   localparam int SY_EXT_IO = 3;
   localparam int SY_N = 4;
endpackage
`default_nettype wire

// *** verilog/cpsi_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// Two-flop synchroniser, one lane per pin
// -------------------------------------------------------------
module cpsi_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_i, // Core clock
   input wire logic rst_i, // Synchronous reset
   input wire logic ce_i, // Clock enable
   input wire logic [WIDTH-1:0] d_i, // Asynchronous pins
   output logic [WIDTH-1:0] q_o // Synchronised copies
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_lane
         // First stage feeds only the second stage
         always_ff @(posedge clk_i) begin
            // Reset to the idle-high pin level, so no false edge follows reset
            if (rst_i) begin
               meta_r[g] <= 1'b1;
               q_r[g] <= 1'b1;
            end else if (ce_i) begin
               meta_r[g] <= d_i[g];
               q_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign q_o = q_r;
endmodule
`default_nettype wire

// *** verilog/cpsi_card_port.sv ***
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Slot code 00 none, 01 external, 1X internal
// - Slot select routes only, never powers cards
// - Bypass drives lines from line-control registers
// - Reading the cause register clears latched causes
// - Each cause masked by its enable bit
// - Causes come only from the selected interface
// - Clock stop mode lives at transmit control bit 7
// - Sync: direct mode bit picks line or UART
// - Bit counter terminal count sets cause bit 7 in sync mode
// - Masked causes still latch, no interrupt
module cpsi_card_port
   import cpsi_pkg::*;
(
   input wire logic clk_i, // 200 MHz core clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic ce_i, // Clock enable, freezes all state when low
   input wire logic [WB_AW-1:0] adr_i, // Wishbone byte address
   input wire logic [WB_DW-1:0] dat_i, // Wishbone write data
   output logic [WB_DW-1:0] dat_o, // Wishbone read data
   input wire logic we_i, // Wishbone write enable
   input wire logic [3:0] sel_i, // Wishbone byte lanes
   input wire logic cyc_i, // Wishbone cycle
   input wire logic stb_i, // Wishbone strobe
   output logic ack_o, // Wishbone acknowledge
   output logic irq_o, // Card interrupt, level
   input wire logic [7:0] int_evt_i, // Internal interface event pulses
   input wire logic [7:0] ext_evt_i, // External interface event pulses
   input wire logic uart_tx_i, // UART serial data out
   input wire logic uart_tx_en_i, // UART wants to drive the line
   output logic uart_rx_o, // Selected line back to the UART
   input wire logic int_clk_i, // Internal card clock pin
   input wire logic ext_clk_i, // External card clock pin
   input wire logic int_io_i, // Internal card I/O pin level
   output logic int_io_o, // Internal card I/O drive value
   output logic int_io_oe_n_o, // Internal card I/O enable, low drives
   input wire logic ext_io_i, // External card I/O pin level
   output logic ext_io_o, // External card I/O drive value
   output logic ext_io_oe_n_o, // External card I/O enable, low drives
   output logic sync_clock_stop_mode_o, // Clock start/stop mode to clock gen
   output logic tx_mode_o // Transmit (1) or receive (0) direction
);
   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   logic [7:0] port_sel_r, cause_r, cause_nxt, ien_r, txc_r, int_ctl_r, ext_ctl_r;
   logic [7:0] len_max_r, len_cnt_r, rd_byte, set_w, evt_w, wbyte_w;
   logic len_run_r, term_r, ack_r, int_clk_d_r, ext_clk_d_r, card_clk_d_r;
   logic sel_int_w, sel_ext_w, sync_w, direct_w, card_clk_w, card_fall_w;
   logic req_w, wr_w, rd_cause_w, int_io_r, int_oe_n_r, ext_io_r, ext_oe_n_r, rx_r;
   logic [WB_DW-1:0] rdat_r;
   logic [SY_N-1:0] pin_s;
   logic [1:0] slot_w;
   logic [15:0] idx_w;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   cpsi_sync #(
      .WIDTH(SY_N)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({ext_io_i, int_io_i, ext_clk_i, int_clk_i}),
      .q_o(pin_s)
   );

   // -------------------------------------------------------------
   // Decodes
   // -------------------------------------------------------------
   // Slot select decode
   // slot decode
   assign slot_w = port_sel_r[SEL_SLOT_HI:SEL_SLOT_LO];
   assign sel_int_w = slot_w[1];
   assign sel_ext_w = (slot_w == SLOT_EXT);
   assign sync_w = txc_r[TXC_SYNC];
   assign direct_w = port_sel_r[SEL_BYPASS] | (sync_w & txc_r[TXC_DIRECT]);
   assign card_clk_w = sel_int_w ? pin_s[SY_INT_CLK] : (sel_ext_w & pin_s[SY_EXT_CLK]);
   assign card_fall_w = card_clk_d_r & ~card_clk_w;

   // Bus decode; one-cycle answer, unmapped reads give zero
   assign req_w = cyc_i & stb_i & ~ack_r;
   assign wr_w = req_w & we_i & sel_i[0];
   assign idx_w = adr_i[WB_AW-1:2];
   assign wbyte_w = dat_i[7:0];
   assign rd_cause_w = req_w & ~we_i & (idx_w == IDX_IRQ_CAUSE);

   // Event gather
   // selected interface only
   assign evt_w = sel_int_w ? int_evt_i : (sel_ext_w ? ext_evt_i : RST_BYTE);
   // terminal count replaces cause 7 in sync
   assign set_w = {(sync_w ? term_r : evt_w[IRQ_BIT_LEN]), evt_w[IRQ_BIT_LEN-1:0]};

   // -------------------------------------------------------------
   // Wishbone slave
   // -------------------------------------------------------------
   // Read mux
   always_comb begin
      rd_byte = RST_BYTE;
      unique case (idx_w)
         IDX_PORT_SEL: rd_byte = port_sel_r;
         IDX_IRQ_CAUSE: rd_byte = cause_r;
         IDX_IRQ_ENABLE: rd_byte = ien_r;
         IDX_TX_CTRL: rd_byte = txc_r;
         IDX_INT_LINE: rd_byte = int_ctl_r;
         IDX_EXT_LINE: rd_byte = ext_ctl_r;
         IDX_BIT_LEN: rd_byte = len_cnt_r;
         default: rd_byte = RST_BYTE;
      endcase
   end

   // Ack and read data, registered; ack drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= '0;
      end else if (ce_i) begin
         ack_r <= req_w;
         if (req_w && !we_i) begin
            rdat_r <= {{(WB_DW-REG_W){1'b0}}, rd_byte};
         end
      end
   end

   assign ack_o = ack_r;
   assign dat_o = rdat_r;

   // -------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------
   // Port select; only routing, no supply side effects
   // routing only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_sel_r <= RST_BYTE;
      end else if (ce_i && wr_w && idx_w == IDX_PORT_SEL) begin
         port_sel_r <= wbyte_w & SEL_WMASK;
      end
   end

   // Enable mask and transmit control
   // clock stop at bit 7
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ien_r <= RST_BYTE;
         txc_r <= RST_BYTE;
      end else if (ce_i && wr_w) begin
         if (idx_w == IDX_IRQ_ENABLE) begin
            ien_r <= wbyte_w;
         end
         if (idx_w == IDX_TX_CTRL) begin
            txc_r <= wbyte_w & TXC_WMASK;
         end
      end
   end

   assign sync_clock_stop_mode_o = txc_r[TXC_CLK_STOP];
   assign tx_mode_o = txc_r[TXC_TX_MODE];

   // Line control; sample bit follows each pin on its own rising clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_ctl_r <= RST_BYTE;
         ext_ctl_r <= RST_BYTE;
         // Idle-high like the synchronised pins: no false rise after reset
         int_clk_d_r <= 1'b1;
         ext_clk_d_r <= 1'b1;
      end else if (ce_i) begin
         int_clk_d_r <= pin_s[SY_INT_CLK];
         ext_clk_d_r <= pin_s[SY_EXT_CLK];
         if (wr_w && idx_w == IDX_INT_LINE) begin
            int_ctl_r[LN_DIR:LN_DATA] <= wbyte_w[LN_DIR:LN_DATA];
         end
         if (wr_w && idx_w == IDX_EXT_LINE) begin
            ext_ctl_r[LN_DIR:LN_DATA] <= wbyte_w[LN_DIR:LN_DATA];
         end
         if (pin_s[SY_INT_CLK] && !int_clk_d_r) begin
            int_ctl_r[LN_SAMPLE] <= pin_s[SY_INT_IO];
         end
         if (pin_s[SY_EXT_CLK] && !ext_clk_d_r) begin
            ext_ctl_r[LN_SAMPLE] <= pin_s[SY_EXT_IO];
         end
      end
   end

   // -------------------------------------------------------------
   // Bit length counter
   // -------------------------------------------------------------
   // Counts falling card clock edges; stops at the loaded value and
   // must be reloaded. A zero load leaves it idle.
   // count to terminal
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         len_max_r <= RST_BYTE;
         len_cnt_r <= RST_BYTE;
         len_run_r <= 1'b0;
         term_r <= 1'b0;
         card_clk_d_r <= 1'b0;
      end else if (ce_i) begin
         card_clk_d_r <= card_clk_w;
         term_r <= 1'b0;
         if (wr_w && idx_w == IDX_BIT_LEN) begin
            len_max_r <= wbyte_w;
            len_cnt_r <= RST_BYTE;
            len_run_r <= (wbyte_w != RST_BYTE);
         end else if (len_run_r && card_fall_w) begin
            len_cnt_r <= len_cnt_r + 8'h01;
            if (len_cnt_r + 8'h01 == len_max_r) begin
               len_run_r <= 1'b0;
               term_r <= 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Interrupt causes
   // -------------------------------------------------------------
   // Clear by read or by writing ones; a new event beats the clear so
   // that nothing is lost in the clearing cycle
   // latch regardless of mask
   always_comb begin
      cause_nxt = cause_r;
      if (rd_cause_w) begin
         cause_nxt = RST_BYTE;
      end
      if (wr_w && idx_w == IDX_IRQ_CAUSE) begin
         cause_nxt = cause_nxt & ~wbyte_w;
      end
      cause_nxt = cause_nxt | set_w;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_r <= RST_BYTE;
      end else if (ce_i) begin
         cause_r <= cause_nxt;
      end
   end

   assign irq_o = |(cause_r & ien_r);

   // -------------------------------------------------------------
   // Card line routing
   // -------------------------------------------------------------
   // Registered pin drive; unselected lines are released unless direct
   // control owns them, so two drivers never fight on one card
   // line source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_io_r <= 1'b1;
         int_oe_n_r <= 1'b1;
         ext_io_r <= 1'b1;
         ext_oe_n_r <= 1'b1;
      end else if (ce_i) begin
         if (direct_w) begin
            int_io_r <= int_ctl_r[LN_DATA];
            int_oe_n_r <= ~int_ctl_r[LN_DIR];
            ext_io_r <= ext_ctl_r[LN_DATA];
            ext_oe_n_r <= ~ext_ctl_r[LN_DIR];
         end else begin
            int_io_r <= uart_tx_i;
            int_oe_n_r <= ~(sel_int_w & uart_tx_en_i);
            ext_io_r <= uart_tx_i;
            ext_oe_n_r <= ~(sel_ext_w & uart_tx_en_i);
         end
      end
   end

   assign int_io_o = int_io_r;
   assign int_io_oe_n_o = int_oe_n_r;
   assign ext_io_o = ext_io_r;
   assign ext_io_oe_n_o = ext_oe_n_r;

   // Receive path; idle high when nothing selected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_r <= 1'b1;
      end else if (ce_i) begin
         rx_r <= sel_int_w ? pin_s[SY_INT_IO] : (~sel_ext_w | pin_s[SY_EXT_IO]);
      end
   end

   assign uart_rx_o = rx_r;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_read_clears;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && rd_cause_w && set_w == RST_BYTE) |=> (cause_r == RST_BYTE);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("cause register not cleared by read");

   property p_set_wins;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && set_w != RST_BYTE) |=> ((cause_r & $past(set_w)) == $past(set_w));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost in clear cycle");

   property p_mask_blocks;
      @(posedge clk_i) disable iff (rst_i)
      (ien_r == RST_BYTE) |-> !irq_o;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks)
      else $error("interrupt with all causes masked");

   property p_irq_raise;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && (set_w & ien_r) != RST_BYTE && !(wr_w && idx_w == IDX_IRQ_ENABLE))
         |=> irq_o;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("enabled cause did not raise interrupt");

   property p_none_quiet;
      @(posedge clk_i) disable iff (rst_i)
      (slot_w == SLOT_NONE && !sync_w) |-> (set_w == RST_BYTE);
   endproperty
   a_none_quiet: assert property (p_none_quiet)
      else $error("event taken with no interface selected");

   property p_ext_only;
      @(posedge clk_i) disable iff (rst_i)
      (slot_w == SLOT_EXT) |-> (set_w[IRQ_BIT_LEN-1:0] == ext_evt_i[IRQ_BIT_LEN-1:0]);
   endproperty
   a_ext_only: assert property (p_ext_only)
      else $error("external slot took foreign events");

   property p_bypass_drive;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && port_sel_r[SEL_BYPASS])
         |=> (int_io_o == $past(int_ctl_r[LN_DATA])
            && ext_io_oe_n_o == !$past(ext_ctl_r[LN_DIR]));
   endproperty
   a_bypass_drive: assert property (p_bypass_drive)
      else $error("bypass line not from line control");

   property p_uart_path;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && sel_int_w && !direct_w)
         |=> (int_io_o == $past(uart_tx_i) && int_io_oe_n_o == !$past(uart_tx_en_i)
            && ext_io_oe_n_o);
   endproperty
   a_uart_path: assert property (p_uart_path)
      else $error("internal slot not on UART path");

   property p_term_sets;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && term_r && sync_w) |=> cause_r[IRQ_BIT_LEN];
   endproperty
   a_term_sets: assert property (p_term_sets)
      else $error("terminal count did not set cause 7");

   property p_clk_stop_bit;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr_w && idx_w == IDX_TX_CTRL)
         |=> (sync_clock_stop_mode_o == $past(dat_i[TXC_CLK_STOP]));
   endproperty
   a_clk_stop_bit: assert property (p_clk_stop_bit)
      else $error("clock stop mode not at bit 7");
endmodule
`default_nettype wire

// *** bench/cpsi_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// Card on one slot: clock source and pulled-up I/O line
// -------------------------------------------------------------
module cpsi_card_model (
   input wire logic clk_i, // Core clock
   input wire logic run_i, // Card clock runs while high
   input wire logic val_i, // Card data while line released
   input wire logic io_i, // Reader drive value
   input wire logic oe_n_i, // Reader enable, low drives
   output logic clk_o, // Card clock
   output logic line_o // Resolved line level
);
   logic [2:0] div_r;
   // Clock stands high between frames, so a stop holds the high level
   always_ff @(posedge clk_i) begin
      div_r <= run_i ? div_r + 3'h1 : 3'h0;
      clk_o <= run_i ? (div_r == 3'h7 ? ~clk_o : clk_o) : 1'b1;
   end
   // Reader wins while driving; card answers only on a released line
   assign line_o = !oe_n_i ? io_i : val_i;
endmodule
`default_nettype wire

// *** bench/tb_card_port_select_and_irq_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_card_port_select_and_irq_status;
   import cpsi_pkg::*;
   logic clk, rst, ce, we, cyc, stb, ack, irq, utx, utx_en, urx;
   logic [WB_AW-1:0] adr;
   logic [WB_DW-1:0] wdat, rdat;
   logic [3:0] sel;
   logic [7:0] int_evt, ext_evt, lf, rd, v;
   logic int_clk, ext_clk, int_ln, ext_ln, int_io, int_oe_n, ext_io, ext_oe_n;
   logic stop_mode, tx_mode, run_int, run_ext, cv_int, cv_ext;
   logic [1:0] sl;
   int failures, n_tests, cyc_cnt;

   cpsi_card_port dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce), .adr_i(adr), .dat_i(wdat),
      .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
      .irq_o(irq), .int_evt_i(int_evt), .ext_evt_i(ext_evt), .uart_tx_i(utx),
      .uart_tx_en_i(utx_en), .uart_rx_o(urx), .int_clk_i(int_clk), .ext_clk_i(ext_clk),
      .int_io_i(int_ln), .int_io_o(int_io), .int_io_oe_n_o(int_oe_n), .ext_io_i(ext_ln),
      .ext_io_o(ext_io), .ext_io_oe_n_o(ext_oe_n), .sync_clock_stop_mode_o(stop_mode),
      .tx_mode_o(tx_mode));
   cpsi_card_model m_int (.clk_i(clk), .run_i(run_int), .val_i(cv_int), .io_i(int_io),
      .oe_n_i(int_oe_n), .clk_o(int_clk), .line_o(int_ln));
   cpsi_card_model m_ext (.clk_i(clk), .run_i(run_ext), .val_i(cv_ext), .io_i(ext_io),
      .oe_n_i(ext_oe_n), .clk_o(ext_clk), .line_o(ext_ln));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Level the UART should see for a slot code
   function automatic logic exp_rx(input logic [1:0] s, input logic i, input logic e);
      return s[1] ? i : (s == SLOT_EXT ? e : 1'b1);
   endfunction
   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hF;
      adr <= {idx, 2'b00}; wdat <= {24'h000000, d};
      n = 0;
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 100);
      // A bus wait that runs out counts as a mismatch and ends the run
      if (ack !== 1'b1) begin failures++; test_done; end
      rd = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input logic [7:0] i, input logic [7:0] e);
      @(posedge clk); int_evt <= i; ext_evt <= e;
      @(posedge clk); int_evt <= 8'h00; ext_evt <= 8'h00;
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
   // Cut a hang short well past the expected few hundred cycles
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin failures++; test_done; end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      failures = 0; n_tests = 0; cyc_cnt = 0; lf = 8'h3D;
      rst = 1'b1; ce = 1'b1; we = 1'b0; cyc = 1'b0; stb = 1'b0; sel = 4'h0;
      adr = '0; wdat = '0; int_evt = 8'h00; ext_evt = 8'h00; utx = 1'b1; utx_en = 1'b0;
      run_int = 1'b0; run_ext = 1'b0; cv_int = 1'b1; cv_ext = 1'b1;
      waitc(2);
      rst <= 1'b0;
      wb(0, IDX_PORT_SEL, 8'h00); `CHK("sel_rst", RST_BYTE, rd)
      wb(0, IDX_IRQ_CAUSE, 8'h00); `CHK("cause_rst", RST_BYTE, rd)
      `CHK("irq_rst", 1'b0, irq)
      lf = lfsr(lf);
      wb(1, IDX_PORT_SEL, lf); wb(0, IDX_PORT_SEL, 8'h00);
      `CHK("sel_rb", lf & SEL_WMASK, rd)
      // Every slot code: UART drives only the chosen line, others released
      for (int s = 0; s < 4; s++) begin
         sl = s[1:0]; lf = lfsr(lf); v = lf;
         wb(1, IDX_PORT_SEL, {4'h0, sl, 2'b00});
         @(posedge clk); utx_en <= 1'b1; utx <= v[0]; cv_int <= v[1]; cv_ext <= v[2];
         waitc(3);
         `CHK("int_oe_n", ~sl[1], int_oe_n)
         `CHK("ext_oe_n", ~(sl == SLOT_EXT), ext_oe_n)
         if (sl[1]) `CHK("int_io", v[0], int_io)
         if (sl == SLOT_EXT) `CHK("ext_io", v[0], ext_io)
         @(posedge clk); utx_en <= 1'b0;
         waitc(6);
         `CHK("uart_rx", exp_rx(sl, v[1], v[2]), urx)
         `CHK("oe_idle", 2'b11, {int_oe_n, ext_oe_n})
      end
      // Bypass: both lines follow their own line-control registers
      wb(1, IDX_INT_LINE, 8'h02); wb(1, IDX_EXT_LINE, 8'h03); wb(1, IDX_PORT_SEL, 8'h02);
      waitc(2);
      `CHK("byp_int", 2'b00, {int_io, int_oe_n})
      `CHK("byp_ext", 2'b10, {ext_io, ext_oe_n})
      // Causes: masked latch, read clear, only the selected interface
      wb(1, IDX_PORT_SEL, 8'h08); wb(1, IDX_IRQ_ENABLE, 8'h00);
      lf = lfsr(lf); v = (lf & 8'hFE) | 8'h02;
      pulse(v, ~v); waitc(2);
      `CHK("irq_masked", 1'b0, irq)
      wb(0, IDX_IRQ_CAUSE, 8'h00); `CHK("cause_int", v, rd)
      wb(0, IDX_IRQ_CAUSE, 8'h00); `CHK("cause_clr", 8'h00, rd)
      wb(1, IDX_IRQ_ENABLE, v);
      pulse(~v, 8'h00); waitc(2);
      `CHK("irq_off", 1'b0, irq)
      pulse(8'h02, 8'h00); waitc(2);
      `CHK("irq_on", 1'b1, irq)
      wb(0, IDX_IRQ_CAUSE, 8'h00); `CHK("cause_both", ~v | 8'h02, rd)
      waitc(1); `CHK("irq_drop", 1'b0, irq)
      // Clock-stop sync sequence on the external slot, UART path first
      wb(1, IDX_PORT_SEL, 8'h04); wb(1, IDX_IRQ_ENABLE, 8'h80);
      @(posedge clk); utx_en <= 1'b1; utx <= 1'b0;
      wb(1, IDX_TX_CTRL, 8'hA0); waitc(2);
      `CHK("stop_mode", 1'b1, stop_mode)
      `CHK("sync_uart", 1'b0, ext_io)
      @(posedge clk); utx <= 1'b1;
      wb(1, IDX_TX_CTRL, 8'hE0); wb(1, IDX_EXT_LINE, 8'h02); waitc(2);
      `CHK("sync_low", 2'b00, {ext_io, ext_oe_n})
      wb(1, IDX_TX_CTRL, 8'hE1); wb(1, IDX_BIT_LEN, 8'h01);
      `CHK("tx_mode", 1'b1, tx_mode)
      wb(1, IDX_EXT_LINE, 8'h03); waitc(2);
      `CHK("sync_high", 2'b10, {ext_io, ext_oe_n})
      wb(1, IDX_TX_CTRL, 8'h61); waitc(1);
      `CHK("stop_rel", 1'b0, stop_mode)
      // Bit counter: three card clock falls reach the loaded value
      @(posedge clk); utx_en <= 1'b0;
      wb(1, IDX_TX_CTRL, 8'h20); wb(0, IDX_IRQ_CAUSE, 8'h00); wb(1, IDX_BIT_LEN, 8'h03);
      @(posedge clk); run_ext <= 1'b1;
      waitc(30); `CHK("cnt_early", 1'b0, irq)
      waitc(20); `CHK("cnt_irq", 1'b1, irq)
      @(posedge clk); run_ext <= 1'b0;
      wb(0, IDX_IRQ_CAUSE, 8'h00); `CHK("cnt_cause", 8'h80, rd)
      test_done;
   end
endmodule
`default_nettype wire
